// ===== src/vlan_edit_pkg.sv
// package: constants, stream and table types, crc step for the vlan tag editor
package vlan_edit_pkg;
    // sizes
    localparam int NPORT   = 8;
    localparam int PORT_W  = 3;
    localparam int NVLAN   = 255;
    localparam int IDX_W   = 8;
    localparam int VID_W   = 12;
    localparam int ADDR_W  = 12;
    localparam int HDR_LEN = 16;
    localparam int MAC_LEN = 12;
    localparam int TAG_LEN = 4;
    localparam int FCS_LEN = 4;

    // frame constants and reset values
    localparam logic [15:0] TPID     = 16'h8100;
    localparam logic [11:0] INIT_VID = 12'h001;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;

    // register map, byte addresses, and the page number of the vlan table in reg_addr[11:10]
    localparam logic [11:0] REG_PVID_BASE = 12'h000;
    localparam logic [11:0] REG_EGR_TAG   = 12'h020;
    localparam logic [11:0] REG_DROP_CNT  = 12'h024;
    localparam logic [11:0] REG_FWD_CNT   = 12'h028;
    localparam logic [11:0] REG_STATE     = 12'h02C;
    localparam logic [1:0]  REG_VLAN_PAGE = 2'h1;

    // vlan entry word layout
    localparam int VID_LSB   = 0;
    localparam int MEM_LSB   = 12;
    localparam int VALID_BIT = 31;

    typedef enum logic [5:0] {
        S_HDR  = 6'h01,
        S_DEC  = 6'h02,
        S_OUT  = 6'h04,
        S_BODY = 6'h08,
        S_FCS  = 6'h10,
        S_DROP = 6'h20
    } state_t;

    typedef struct packed {
        logic [PORT_W-1:0] rx_port;
        logic [PORT_W-1:0] tx_port;
        logic [7:0]        data;
        logic              sop;
        logic              eop;
    } in_beat_t;

    typedef struct packed {
        logic [7:0] data;
        logic       sop;
        logic       eop;
    } out_beat_t;

    typedef struct packed {
        logic             valid;
        logic [NPORT-1:0] members;
        logic [VID_W-1:0] vid;
    } vlan_entry_t;

    localparam vlan_entry_t INIT_ENTRY = '{valid: 1'b1, members: '1, vid: INIT_VID};

    // one byte of the reflected ethernet crc
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction
endpackage

// ===== src/beat_fifo.sv
// small fifo between the editor and the egress receiver
`timescale 1ns/1ps
`default_nettype none
module beat_fifo #(
    parameter int W     = 10,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    // fill side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    // drain side
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    // pointers wrap by overflow, so depth must be a power of two
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0]  mem_r   [DEPTH];
    logic [W-1:0]  mem_nxt [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]   cnt_r, cnt_nxt;
    logic          wr, rd;

    // honest full and empty from the occupancy count
    assign in_ready  = cnt_r != (AW+1)'(DEPTH);
    assign out_valid = cnt_r != '0;
    assign out_data  = mem_r[rp_r];
    assign wr        = in_valid && in_ready;
    assign rd        = out_valid && out_ready;

    // next pointers, count and storage
    always_comb begin
        mem_nxt = mem_r;
        wp_nxt  = wp_r;
        rp_nxt  = rp_r;
        if (wr) begin
            mem_nxt[wp_r] = in_data;
            wp_nxt        = wp_r + 1'b1;
        end
        if (rd) begin
            rp_nxt = rp_r + 1'b1;
        end
        cnt_nxt = cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            mem_r <= mem_nxt;
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule
`default_nettype wire

// ===== src/vlan_member_table.sv
// vlan table: entries with member masks, lookup by vid
`timescale 1ns/1ps
`default_nettype none
module vlan_member_table (
    // clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        rst_n,
    // software side
    input  wire logic                        wr_en,
    input  wire logic [vlan_edit_pkg::IDX_W-1:0] wr_idx,
    input  wire vlan_edit_pkg::vlan_entry_t  wr_entry,
    input  wire logic [vlan_edit_pkg::IDX_W-1:0] rd_idx,
    output vlan_edit_pkg::vlan_entry_t       rd_entry,
    // lookup
    input  wire logic [vlan_edit_pkg::VID_W-1:0] lk_vid,
    output logic                             lk_hit,
    output logic [vlan_edit_pkg::NPORT-1:0]  lk_members
);
    import vlan_edit_pkg::*;

    vlan_entry_t tbl_r   [NVLAN];
    vlan_entry_t tbl_nxt [NVLAN];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // a valid write to another entry takes its members out of the initial group
    always_comb begin
        tbl_nxt = tbl_r;
        if (wr_en && wr_idx < IDX_W'(NVLAN)) begin
            tbl_nxt[wr_idx] = wr_entry;
            if (wr_idx != '0 && wr_entry.valid) begin
                tbl_nxt[0].members = tbl_r[0].members & ~wr_entry.members;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NVLAN; i++) begin
                tbl_r[i] <= '0;
            end
            tbl_r[0] <= INIT_ENTRY;
        end else begin
            tbl_r <= tbl_nxt;
        end
    end

    assign rd_entry = (rd_idx < IDX_W'(NVLAN)) ? tbl_r[rd_idx] : '0;

    always_comb begin
        lk_hit     = 1'b0;
        lk_members = '0;
        for (int i = NVLAN - 1; i >= 0; i--) begin
            if (tbl_r[i].valid && tbl_r[i].vid == lk_vid) begin
                lk_hit     = 1'b1;
                lk_members = tbl_r[i].members;
            end
        end
    end

    a_split_initial: assert property (
        wr_en && wr_idx != '0 && wr_idx < IDX_W'(NVLAN) && wr_entry.valid
        |=> (tbl_r[0].members & $past(wr_entry.members)) == '0)
        else $error("initial group kept a moved port");

    a_reset_initial: assert property (
        $rose(rst_n) |-> tbl_r[0] == INIT_ENTRY && !tbl_r[1].valid)
        else $error("table not at reset contents");

    a_entry_stored: assert property (
        wr_en && wr_idx != '0 && wr_idx < IDX_W'(NVLAN)
        |=> tbl_r[$past(wr_idx)] == $past(wr_entry))
        else $error("entry write lost");
endmodule
`default_nettype wire

// ===== src/vlan_tag_classify_and_edit.sv
// vlan classifier and egress tag editor with membership filter and fcs regeneration
`timescale 1ns/1ps
`default_nettype none
module vlan_tag_classify_and_edit (
    // clock and reset
    input  wire logic                              core_clk,
    input  wire logic                              rst_n,
    // register port
    input  wire logic [vlan_edit_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [31:0]                       reg_wdata,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    output logic [31:0]                            reg_rdata,
    // ingress stream, fcs already removed
    input  wire logic                              in_valid,
    input  wire vlan_edit_pkg::in_beat_t           in_beat,
    output logic                                   in_ready,
    // egress stream, fcs appended
    output logic                                   out_valid,
    output vlan_edit_pkg::out_beat_t               out_beat,
    input  wire logic                              out_ready
);
    import vlan_edit_pkg::*;

    state_t            st_r, st_nxt;
    logic [7:0]        hdr_r   [HDR_LEN];
    logic [7:0]        hdr_nxt [HDR_LEN];
    logic [4:0]        hc_r, hc_nxt, oi_r, oi_nxt, olen_r, olen_nxt;
    logic [1:0]        fc_r, fc_nxt;
    logic [31:0]       crc_r, crc_nxt;
    logic              short_r, short_nxt, ins_r, ins_nxt, strip_r, strip_nxt;
    logic [PORT_W-1:0] rx_r, rx_nxt, tx_r, tx_nxt;
    logic [VID_W-1:0]  vid_r, vid_nxt;
    logic [31:0]       drop_cnt_r, drop_cnt_nxt, fwd_cnt_r, fwd_cnt_nxt;
    logic [VID_W-1:0]  pvid_r   [NPORT];
    logic [VID_W-1:0]  pvid_nxt [NPORT];
    logic [NPORT-1:0]  egr_tag_r, egr_tag_nxt;
    logic [31:0]       rdata_r, rdata_nxt;
    logic              tagged_w, hit_w, emit, push, buf_ready, pass_w;
    logic [VID_W-1:0]  cls_vid_w;
    logic [NPORT-1:0]  mem_w;
    logic [4:0]        hidx;
    logic [7:0]        hbyte;
    out_beat_t         obeat;
    logic              pvid_sel, tbl_sel, tbl_wr;
    vlan_entry_t       rd_entry, wr_entry;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////
    // classification on the captured header
    always_comb begin
        tagged_w  = (hc_r == 5'(HDR_LEN)) && ({hdr_r[MAC_LEN], hdr_r[MAC_LEN+1]} == TPID);
        cls_vid_w = tagged_w ? {hdr_r[MAC_LEN+2][3:0], hdr_r[MAC_LEN+3]} : pvid_r[rx_r];
    end

    vlan_member_table u_table (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .wr_en      (tbl_wr),
        .wr_idx     (reg_addr[IDX_W+1:2]),
        .wr_entry   (wr_entry),
        .rd_idx     (reg_addr[IDX_W+1:2]),
        .rd_entry   (rd_entry),
        .lk_vid     (cls_vid_w),
        .lk_hit     (hit_w),
        .lk_members (mem_w)
    );

    assign pass_w = hit_w && mem_w[tx_r];

    ////////////////////////////////////////////////////////////////////////
    // outgoing header byte at position oi_r
    always_comb begin
        // original bytes shift behind the tag
        hidx  = (ins_r && oi_r >= 5'(HDR_LEN)) ? oi_r - 5'(TAG_LEN) : oi_r;
        hbyte = hdr_r[hidx[3:0]];
        if (ins_r && oi_r >= 5'(MAC_LEN) && oi_r < 5'(HDR_LEN)) begin
            unique case (oi_r[1:0])
                2'h0: hbyte = TPID[15:8];
                2'h1: hbyte = TPID[7:0];
                2'h2: hbyte = {4'h0, vid_r[11:8]};
                2'h3: hbyte = vid_r[7:0];
            endcase
        end
    end

    // what the editor offers to the buffer in each state
    always_comb begin
        emit     = 1'b0;
        obeat    = '0;
        in_ready = 1'b0;
        unique case (st_r)
            S_HDR:  in_ready = 1'b1;
            S_DEC:  emit = 1'b0;
            S_OUT: begin
                emit  = 1'b1;
                obeat = '{data: hbyte, sop: oi_r == '0, eop: 1'b0};
            end
            S_BODY: begin
                emit     = in_valid;
                in_ready = buf_ready;
                obeat    = '{data: in_beat.data, sop: 1'b0, eop: 1'b0};
            end
            S_FCS: begin
                emit  = 1'b1;
                obeat = '{data: ~crc_r[{fc_r, 3'h0} +: 8], sop: 1'b0, eop: fc_r == 2'(FCS_LEN-1)};
            end
            S_DROP: in_ready = 1'b1;
            default: in_ready = 1'b0;
        endcase
    end

    assign push = emit && buf_ready;

    ////////////////////////////////////////////////////////////////////////
    // frame sequencer
    always_comb begin
        st_nxt    = st_r;
        hdr_nxt   = hdr_r;
        hc_nxt    = hc_r;
        oi_nxt    = oi_r;
        olen_nxt  = olen_r;
        fc_nxt    = fc_r;
        short_nxt = short_r;
        ins_nxt   = ins_r;
        strip_nxt = strip_r;
        rx_nxt    = rx_r;
        tx_nxt    = tx_r;
        vid_nxt   = vid_r;
        fwd_cnt_nxt  = fwd_cnt_r;
        // a clear in the same cycle as a drop still counts that drop
        drop_cnt_nxt = (reg_wr && reg_addr == REG_DROP_CNT) ? '0 : drop_cnt_r;
        crc_nxt = (push && st_r != S_FCS) ? crc_byte(crc_r, obeat.data) : crc_r;
        unique case (st_r)
            S_HDR: begin
                if (in_valid) begin
                    hdr_nxt[hc_r[3:0]] = in_beat.data;
                    hc_nxt = hc_r + 5'h01;
                    if (hc_r == '0) begin
                        rx_nxt = in_beat.rx_port;
                        tx_nxt = in_beat.tx_port;
                    end
                    if (in_beat.eop || hc_r == 5'(HDR_LEN-1)) begin
                        short_nxt = in_beat.eop;
                        st_nxt    = S_DEC;
                    end
                end
            end
            S_DEC: begin
                ins_nxt   = egr_tag_r[tx_r] && !tagged_w && hc_r >= 5'(MAC_LEN);
                strip_nxt = !egr_tag_r[tx_r] && tagged_w;
                vid_nxt   = cls_vid_w;
                olen_nxt  = ins_nxt ? hc_r + 5'(TAG_LEN) : (strip_nxt ? 5'(MAC_LEN) : hc_r);
                oi_nxt    = '0;
                fc_nxt    = '0;
                crc_nxt   = CRC_INIT;
                if (!pass_w) begin
                    drop_cnt_nxt = drop_cnt_nxt + 32'h1;
                    hc_nxt       = '0;
                    st_nxt       = short_r ? S_HDR : S_DROP;
                end else begin
                    st_nxt = S_OUT;
                end
            end
            S_OUT: begin
                if (push) begin
                    oi_nxt = oi_r + 5'h01;
                    if (oi_r == olen_r - 5'h01) begin
                        st_nxt = short_r ? S_FCS : S_BODY;
                    end
                end
            end
            S_BODY: begin
                if (push && in_beat.eop) begin
                    st_nxt = S_FCS;
                end
            end
            S_FCS: begin
                if (push) begin
                    fc_nxt = fc_r + 2'h1;
                    if (fc_r == 2'(FCS_LEN-1)) begin
                        hc_nxt      = '0;
                        fwd_cnt_nxt = fwd_cnt_r + 32'h1;
                        st_nxt      = S_HDR;
                    end
                end
            end
            S_DROP: begin
                if (in_valid && in_beat.eop) begin
                    st_nxt = S_HDR;
                end
            end
            default: st_nxt = S_HDR;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= S_HDR;
            for (int i = 0; i < HDR_LEN; i++) begin
                hdr_r[i] <= '0;
            end
            hc_r       <= '0;
            oi_r       <= '0;
            olen_r     <= '0;
            fc_r       <= '0;
            crc_r      <= CRC_INIT;
            short_r    <= 1'b0;
            ins_r      <= 1'b0;
            strip_r    <= 1'b0;
            rx_r       <= '0;
            tx_r       <= '0;
            vid_r      <= INIT_VID;
            drop_cnt_r <= '0;
            fwd_cnt_r  <= '0;
        end else begin
            st_r       <= st_nxt;
            hdr_r      <= hdr_nxt;
            hc_r       <= hc_nxt;
            oi_r       <= oi_nxt;
            olen_r     <= olen_nxt;
            fc_r       <= fc_nxt;
            crc_r      <= crc_nxt;
            short_r    <= short_nxt;
            ins_r      <= ins_nxt;
            strip_r    <= strip_nxt;
            rx_r       <= rx_nxt;
            tx_r       <= tx_nxt;
            vid_r      <= vid_nxt;
            drop_cnt_r <= drop_cnt_nxt;
            fwd_cnt_r  <= fwd_cnt_nxt;
        end
    end

    // two-entry buffer so an egress stall loses no byte
    beat_fifo #(.W($bits(out_beat_t)), .DEPTH(2)) u_fifo (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_valid  (emit),
        .in_data   (obeat),
        .in_ready  (buf_ready),
        .out_valid (out_valid),
        .out_data  (out_beat),
        .out_ready (out_ready)
    );

    ////////////////////////////////////////////////////////////////////////
    // register port
    assign pvid_sel = reg_addr < REG_EGR_TAG;
    assign tbl_sel  = reg_addr[11:10] == REG_VLAN_PAGE && reg_addr[IDX_W+1:2] < IDX_W'(NVLAN);
    assign tbl_wr   = reg_wr && tbl_sel;
    assign wr_entry = '{valid:   reg_wdata[VALID_BIT],
                        members: reg_wdata[MEM_LSB +: NPORT],
                        vid:     reg_wdata[VID_LSB +: VID_W]};

    always_comb begin
        pvid_nxt    = pvid_r;
        egr_tag_nxt = egr_tag_r;
        rdata_nxt   = '0;
        if (reg_wr && pvid_sel) begin
            pvid_nxt[reg_addr[PORT_W+1:2]] = reg_wdata[VID_W-1:0];
        end
        if (reg_wr && reg_addr == REG_EGR_TAG) begin
            egr_tag_nxt = reg_wdata[NPORT-1:0];
        end
        if (reg_rd) begin
            if (pvid_sel) begin
                rdata_nxt = 32'(pvid_r[reg_addr[PORT_W+1:2]]);
            end else if (tbl_sel) begin
                rdata_nxt[VALID_BIT]           = rd_entry.valid;
                rdata_nxt[MEM_LSB +: NPORT]    = rd_entry.members;
                rdata_nxt[VID_LSB +: VID_W]    = rd_entry.vid;
            end else if (reg_addr == REG_EGR_TAG) begin
                rdata_nxt = 32'(egr_tag_r);
            end else if (reg_addr == REG_DROP_CNT) begin
                rdata_nxt = drop_cnt_r;
            end else if (reg_addr == REG_FWD_CNT) begin
                rdata_nxt = fwd_cnt_r;
            end else if (reg_addr == REG_STATE) begin
                rdata_nxt = 32'(st_r);
            end
        end
    end

    // all ports untagged, port vid one
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NPORT; i++) begin
                pvid_r[i] <= INIT_VID;
            end
            egr_tag_r <= '0;
            rdata_r   <= '0;
        end else begin
            pvid_r    <= pvid_nxt;
            egr_tag_r <= egr_tag_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_last_fcs;
        push && obeat.eop;
    endsequence

    sequence s_reject;
        st_r == S_DEC && !pass_w;
    endsequence

    a_tpid_detect: assert property (
        st_r == S_DEC && hc_r == 5'(HDR_LEN) && hdr_r[MAC_LEN] == TPID[15:8]
        && hdr_r[MAC_LEN+1] == TPID[7:0] |-> tagged_w) else $error("tpid missed");
    a_insert_grows: assert property (
        st_r == S_DEC && pass_w && ins_nxt |=> olen_r == $past(hc_r) + 5'(TAG_LEN))
        else $error("insert length wrong");
    a_insert_shift: assert property (
        push && st_r == S_OUT && ins_r && oi_r >= 5'(HDR_LEN)
        |-> obeat.data == hdr_r[4'(oi_r - 5'(TAG_LEN))]) else $error("shifted byte wrong");
    a_tag_prio_zero: assert property (
        push && st_r == S_OUT && ins_r && oi_r == 5'(MAC_LEN+2)
        |-> obeat.data == {4'h0, vid_r[11:8]}) else $error("tag control byte wrong");
    a_pvid_class: assert property (
        st_r == S_DEC && !tagged_w |=> vid_r == $past(pvid_r[rx_r]))
        else $error("untagged frame not on port vid");
    a_reject_silent: assert property (
        s_reject |=> (st_r == S_HDR || st_r == S_DROP) && !emit ##1 st_r != S_OUT)
        else $error("non-member frame sent");
    a_strip_cut: assert property (
        push && st_r == S_OUT && strip_r && oi_r == olen_r - 5'h01
        |-> olen_r == 5'(MAC_LEN) ##1 st_r != S_OUT) else $error("tag not stripped");
    a_keep_tag: assert property (
        push && st_r == S_OUT && !ins_r |-> obeat.data == hdr_r[oi_r[3:0]])
        else $error("header byte altered");
    a_fcs_close: assert property (
        s_last_fcs |-> fc_r == 2'(FCS_LEN-1) && obeat.data == ~crc_r[31:24] ##1 st_r == S_HDR)
        else $error("fcs end wrong");
endmodule
`default_nettype wire

// ===== tb/egress_sink.sv
// egress receiver model: collects beats and stalls on a fixed pattern
`timescale 1ns/1ps
`default_nettype none
module egress_sink (
    // clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    // egress stream
    input  wire logic                      out_valid,
    input  wire vlan_edit_pkg::out_beat_t  out_beat,
    output logic                           out_ready
);
    import vlan_edit_pkg::*;
    logic [9:0] got[$];
    logic [2:0] tick_r;
    // three stalled cycles in eight, long enough to fill the two-entry buffer
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_r <= 3'h0;
            out_ready <= 1'b0;
        end else begin
            tick_r <= tick_r + 3'h1;
            out_ready <= (tick_r < 3'h5);
            if (out_valid && out_ready) got.push_back(out_beat);
        end
    end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the vlan classifier and tag editor
`timescale 1ns/1ps
`default_nettype none
module tb;
    import vlan_edit_pkg::*;
    typedef logic [7:0] bq_t[$];
    logic              core_clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [31:0]       reg_wdata = '0;
    logic [31:0]       reg_rdata;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic              in_valid = 1'b0;
    logic              in_ready;
    logic              out_valid;
    logic              out_ready;
    in_beat_t          in_beat = '0;
    out_beat_t         out_beat;
    int                failures = 0;
    int                n_compared = 0;
    bq_t               fr;
    bq_t               ex;
    always #10 core_clk = ~core_clk;
    vlan_tag_classify_and_edit i_vlan_tag_classify_and_edit (.core_clk, .rst_n, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .in_valid, .in_beat, .in_ready, .out_valid, .out_beat, .out_ready);
    egress_sink i_egress_sink (.core_clk, .rst_n, .out_valid, .out_beat, .out_ready);
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one idle edge after the strobe, so a following write never re-raises it in the same step
    task wr(input logic [11:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    // read data is only valid in the cycle after the strobe
    task rd(input logic [11:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk(reg_rdata, exp);
        @(posedge core_clk);
    endtask
    // own crc so that expectations never share the design's function
    function automatic logic [31:0] fcs_of(bq_t q);
        logic [31:0] c;
        c = 32'hFFFFFFFF;
        foreach (q[i]) begin
            c = c ^ {24'h000000, q[i]};
            for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return ~c;
    endfunction
    // sent and expected frame; the tag always carries vid 5
    task mk(input logic tag_in, input logic tag_out);
        fr = {};
        for (int i = 0; i < 12; i++) fr.push_back(8'h10 + 8'(i));
        ex = fr;
        if (tag_in) fr = {fr, 8'h81, 8'h00, 8'h00, 8'h05};
        if (tag_out) ex = {ex, 8'h81, 8'h00, 8'h00, 8'h05};
        fr = {fr, 8'h08, 8'h00, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5};
        ex = {ex, 8'h08, 8'h00, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5};
    endtask
    task send(input logic [PORT_W-1:0] rx, input logic [PORT_W-1:0] tx);
        foreach (fr[i]) begin
            in_valid <= 1'b1;
            in_beat <= '{rx_port: rx, tx_port: tx, data: fr[i], sop: i == 0, eop: i == fr.size() - 1};
            do @(negedge core_clk); while (in_ready !== 1'b1);
            @(posedge core_clk);
        end
        in_valid <= 1'b0;
    endtask
    task expect_out;
        logic [31:0] f;
        f = fcs_of(ex);
        ex = {ex, f[7:0], f[15:8], f[23:16], f[31:24]};
        for (int k = 0; k < 300 && i_egress_sink.got.size() < ex.size(); k++) @(posedge core_clk);
        repeat (6) @(posedge core_clk);
        chk(32'(i_egress_sink.got.size()), 32'(ex.size()));
        foreach (ex[i]) chk({22'h0, i_egress_sink.got[i]}, {22'h0, ex[i], i == 0, i == ex.size() - 1});
        i_egress_sink.got = {};
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        rd(12'h000, 32'h00000001);
        rd(12'h400, 32'h800FF001);
        rd(12'h020, 32'h00000000);
        rd(12'h7FC, 32'h00000000);
        rd(12'h02C, 32'h00000001);
    endtask
    task t_plain;
        mk(1'b0, 1'b0);
        send(3'h0, 3'h3);
        expect_out;
    endtask
    task t_config;
        wr(12'h008, 32'h00000005);
        wr(12'h020, 32'h00000002);
        wr(12'h404, 32'h80012005);
        rd(12'h400, 32'h800ED001);
        rd(12'h020, 32'h00000002);
    endtask
    task t_insert;
        mk(1'b0, 1'b1);
        send(3'h2, 3'h1);
        expect_out;
    endtask
    task t_keep;
        mk(1'b1, 1'b1);
        send(3'h0, 3'h1);
        expect_out;
    endtask
    task t_strip;
        mk(1'b1, 1'b0);
        send(3'h0, 3'h4);
        expect_out;
    endtask
    task t_drop;
        mk(1'b1, 1'b1);
        send(3'h0, 3'h3);
        repeat (40) @(posedge core_clk);
        chk(32'(i_egress_sink.got.size()), 32'h0);
        rd(12'h024, 32'h00000001);
        rd(12'h028, 32'h00000004);
        wr(12'h024, 32'h00000000);
        rd(12'h024, 32'h00000000);
    endtask
    task summarize;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        failures++;
        summarize;
    end
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        t_reset;
        t_plain;
        t_config;
        t_insert;
        t_keep;
        t_strip;
        t_drop;
        summarize;
    end
endmodule
`default_nettype wire
